// ### src/jack_pkg.sv
// Purpose: Constants, types and decode functions for the jack sequencer
// Assumes: pclk at 20 MHz, APB slave with 32-bit data
// Notes:   All sequencer times are whole milliseconds
package jack_pkg;
   localparam int CLK_NS = 50;
   localparam int MS_NS  = 1_000_000;
   localparam int MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;

   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] MASK_ADDR = 8'h04;
   localparam logic [7:0] EVT_ADDR  = 8'h08;
   localparam logic [7:0] STS_ADDR  = 8'h0C;
   localparam logic [7:0] RAMP_ADDR = 8'h10;

   localparam int TDET_EN_BIT = 0;
   localparam int TFORCE_BIT  = 1;
   localparam int ODET_EN_BIT = 2;
   localparam int OFORCE_BIT  = 3;
   localparam int HPT_EN_BIT  = 4;
   localparam int POL_BIT     = 5;
   localparam int RATE_LSB    = 6;
   localparam int IDEB_LSB    = 8;
   localparam int RDEB_LSB    = 12;
   localparam int MTH_LSB     = 16;
   localparam int HTH_LSB     = 18;
   localparam logic [31:0] CTRL_RST = 32'h0001_0205;

   localparam int EV_INS  = 0;
   localparam int EV_REM  = 1;
   localparam int EV_DONE = 2;

   localparam int ST_PRES  = 0;
   localparam int ST_TYPE  = 1;
   localparam int ST_ORDER = 2;
   localparam int ST_LOAD  = 3;
   localparam int ST_BUSY  = 4;
   localparam int ST_RAMP  = 5;

   localparam int RAMP_GO_BIT = 8;
   localparam logic [7:0]  STEP_RST  = 8'h01;
   localparam logic [15:0] RAMP_HALF = 16'h8000;
   localparam logic [9:0]  LAT_BASE  = 10'h020;

   typedef enum {S_IDLE, S_TYPE_WAIT, S_ORDER_WAIT} seq_t;

   function automatic logic [9:0] ins_deb_ms(input logic [2:0] c);
      case (c)
         3'h0: return 10'h005;
         3'h1: return 10'h00A;
         3'h2: return 10'h014;
         3'h3: return 10'h032;
         3'h4: return 10'h064;
         3'h5: return 10'h0C8;
         3'h6: return 10'h1F4;
         default: return 10'h001;
      endcase
   endfunction : ins_deb_ms

   function automatic logic [9:0] rem_deb_ms(input logic [1:0] c);
      case (c)
         2'h0: return 10'h001;
         2'h1: return 10'h005;
         2'h2: return 10'h00A;
         default: return 10'h014;
      endcase
   endfunction : rem_deb_ms

   function automatic logic [9:0] lat_ms(input logic [1:0] c, input logic four);
      return LAT_BASE << ({1'b0, c} + {2'h0, four});
   endfunction : lat_ms
endpackage : jack_pkg

// ### src/deb_if.sv
// Purpose: Link between the sequencer and the plug debounce filter
// Assumes: Both ends on pclk
// Notes:   Pulses last one cycle
`timescale 1ns/1ps
interface deb_if;
   logic       polarity;
   logic [9:0] ins_ms;
   logic [9:0] rem_ms;
   logic       present;
   logic       ins_pulse;
   logic       rem_pulse;
   modport filt (input polarity, ins_ms, rem_ms, output present, ins_pulse, rem_pulse);
   modport ctl  (output polarity, ins_ms, rem_ms, input present, ins_pulse, rem_pulse);
endinterface : deb_if

// ### src/jack_debounce.sv
// Purpose: Synchronise and debounce the plug sense pin
// Assumes: Debounce times in whole milliseconds
// Notes:   Presence changes only after a full stable interval
`timescale 1ns/1ps
module jack_debounce
   import jack_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYC
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Socket pin
   input  wire logic sense_raw,
   // Sequencer side
   deb_if.filt       d
);
   logic        s1_reg;
   logic        s2_reg;
   logic        pres_reg;
   logic        ins_reg;
   logic        rem_reg;
   logic [15:0] cyc_reg;
   logic [9:0]  ms_reg;

   wire       now_in = s2_reg ^ d.polarity;
   wire       differ = now_in != pres_reg;
   wire [9:0] target = pres_reg ? d.rem_ms : d.ins_ms;
   wire       ms_end = cyc_reg == 16'(MS_CYCLES - 1);
   wire       commit = differ && ms_end && ({1'b0, ms_reg} + 11'h001 >= {1'b0, target});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
      end else begin
         s1_reg <= sense_raw;
         s2_reg <= s1_reg;
      end
   end

   // A bounce back to the held state clears the count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_reg <= 16'h0000;
         ms_reg  <= 10'h000;
      end else if (!differ || commit) begin
         cyc_reg <= 16'h0000;
         ms_reg  <= 10'h000;
      end else if (ms_end) begin
         cyc_reg <= 16'h0000;
         ms_reg  <= ms_reg + 10'h001;
      end else begin
         cyc_reg <= cyc_reg + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pres_reg <= 1'b0;
         ins_reg  <= 1'b0;
         rem_reg  <= 1'b0;
      end else begin
         if (commit) pres_reg <= now_in;
         ins_reg <= commit && now_in;
         rem_reg <= commit && !now_in;
      end
   end

   assign d.present   = pres_reg;
   assign d.ins_pulse = ins_reg;
   assign d.rem_pulse = rem_reg;
endmodule : jack_debounce

// ### src/jack_detect_seq.sv
// Purpose: Jack insertion, plug type, pin order and load test sequencer
// Assumes: Analog comparators hold their result while measured
// Notes:   APB slave with zero wait states
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module jack_detect_seq
   import jack_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Socket and analog comparators
   input  wire logic        plug_sense,
   input  wire logic        type_above,
   input  wire logic        mic_on_second_ring,
   input  wire logic        load_above,
   // Measurement control
   output logic      [1:0]  type_thresh_sel,
   output logic      [1:0]  load_thresh_sel,
   output logic             type_meas_en,
   output logic             order_meas_en,
   output logic      [15:0] ramp_amp,
   output logic             ramp_active,
   // Host interrupt
   output logic             irq
);
   deb_if dbus ();

   jack_debounce #(
      .MS_CYCLES (MS_CYCLES)
   ) u_deb (
      .pclk      (pclk),
      .presetn   (presetn),
      .sense_raw (plug_sense),
      .d         (dbus.filt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Registers and APB decode

   logic [31:0] ctrl_reg;
   logic [2:0]  mask_reg;
   logic [2:0]  ev_reg;
   logic [2:0]  ev_next;
   logic [7:0]  step_reg;
   logic        type_reg;
   logic        order_reg;
   logic        load_reg;

   wire acc     = psel && penable;
   wire wr      = acc && pwrite;
   wire hit_ctl = paddr == CTRL_ADDR;
   wire hit_msk = paddr == MASK_ADDR;
   wire hit_evt = paddr == EVT_ADDR;
   wire hit_sts = paddr == STS_ADDR;
   wire hit_rmp = paddr == RAMP_ADDR;
   wire mapped  = hit_ctl || hit_msk || hit_evt || hit_sts || hit_rmp;

   wire       tdet_en = ctrl_reg[TDET_EN_BIT];
   wire       tforce  = ctrl_reg[TFORCE_BIT];
   wire       odet_en = ctrl_reg[ODET_EN_BIT];
   wire       oforce  = ctrl_reg[OFORCE_BIT];
   wire       hpt_en  = ctrl_reg[HPT_EN_BIT];
   wire [1:0] rate    = ctrl_reg[RATE_LSB +: 2];

   assign dbus.polarity = ctrl_reg[POL_BIT];
   assign dbus.ins_ms   = ins_deb_ms(ctrl_reg[IDEB_LSB +: 3]);
   assign dbus.rem_ms   = rem_deb_ms(ctrl_reg[RDEB_LSB +: 2]);

   assign type_thresh_sel = ctrl_reg[MTH_LSB +: 2];
   assign load_thresh_sel = ctrl_reg[HTH_LSB +: 2];

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   ////////////////////////////////////////////////////////////////////////////
   // Comparator synchronisers

   logic [2:0] an1_reg;
   logic [2:0] an2_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         an1_reg <= 3'h0;
         an2_reg <= 3'h0;
      end else begin
         an1_reg <= {load_above, mic_on_second_ring, type_above};
         an2_reg <= an1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Millisecond base, restarted on insertion so latency is exact

   logic [15:0] cyc_reg;
   logic [9:0]  ms_reg;
   seq_t        state;
   seq_t        state_next;

   wire       ms_end   = cyc_reg == 16'(MS_CYCLES - 1);
   wire [9:0] lat_tgt  = lat_ms(rate, state == S_ORDER_WAIT);
   wire       lat_hit  = ms_end && ({1'b0, ms_reg} + 11'h001 == {1'b0, lat_tgt});
   wire       type_dec = tdet_en ? an2_reg[0] : tforce;
   wire       ord_dec  = odet_en ? an2_reg[1] : oforce;
   wire       done_set = lat_hit && !dbus.rem_pulse
                         && ((state == S_TYPE_WAIT && !type_dec) || state == S_ORDER_WAIT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_reg <= 16'h0000;
      end else if (dbus.ins_pulse || ms_end) begin
         cyc_reg <= 16'h0000;
      end else begin
         cyc_reg <= cyc_reg + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_reg <= 10'h000;
      end else if (dbus.ins_pulse) begin
         ms_reg <= 10'h000;
      end else if (ms_end && state != S_IDLE) begin
         ms_reg <= ms_reg + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Detection sequencer

   always_comb begin
      state_next = state;
      case (state)
         S_IDLE: begin
            if (dbus.ins_pulse) state_next = S_TYPE_WAIT;
         end
         S_TYPE_WAIT: begin
            if (dbus.rem_pulse) state_next = S_IDLE;
            else if (lat_hit) state_next = type_dec ? S_ORDER_WAIT : S_IDLE;
         end
         S_ORDER_WAIT: begin
            if (dbus.rem_pulse || lat_hit) state_next = S_IDLE;
         end
         default: state_next = S_IDLE;
      endcase
   end

   // Forced values skip the measurement drive entirely
   assign type_meas_en  = state == S_TYPE_WAIT && tdet_en;
   assign order_meas_en = state == S_ORDER_WAIT && odet_en;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= S_IDLE;
         type_reg  <= 1'b0;
         order_reg <= 1'b0;
      end else begin
         state <= state_next;
         if (state == S_TYPE_WAIT && lat_hit) begin
            type_reg  <= type_dec;
            order_reg <= odet_en ? 1'b0 : oforce;
         end
         if (state == S_ORDER_WAIT && lat_hit) order_reg <= ord_dec;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event flags and interrupt; a set in the clearing cycle wins

   wire [2:0] ev_set = {done_set, dbus.rem_pulse, dbus.ins_pulse};
   wire [2:0] ev_clr = (wr && hit_evt) ? pwdata[2:0] : 3'h0;

   assign ev_next = (ev_reg & ~ev_clr) | ev_set;
   assign irq     = |(ev_reg & ~mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Load test ramp

   logic        ramp_on_reg;
   logic        decel_reg;
   logic        seen_reg;
   logic [15:0] amp_reg;
   logic [15:0] vel_reg;

   wire        ramp_go   = wr && hit_rmp && pwdata[RAMP_GO_BIT] && hpt_en && !ramp_on_reg;
   wire        ramp_tick = ramp_on_reg && ms_end;
   wire [16:0] amp_sum   = {1'b0, amp_reg} + {1'b0, vel_reg};
   wire [15:0] amp_sat   = amp_sum[16] ? 16'hFFFF : amp_sum[15:0];
   wire [15:0] step_w    = {8'h00, step_reg};
   wire        ramp_last = decel_reg && vel_reg <= step_w;

   // Velocity rises then falls, giving the S shape without a table
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_on_reg <= 1'b0;
         decel_reg   <= 1'b0;
         seen_reg    <= 1'b0;
         amp_reg     <= 16'h0000;
         vel_reg     <= 16'h0000;
         load_reg    <= 1'b0;
      end else if (ramp_go) begin
         ramp_on_reg <= 1'b1;
         decel_reg   <= 1'b0;
         seen_reg    <= 1'b0;
         amp_reg     <= 16'h0000;
         vel_reg     <= 16'h0000;
      end else if (ramp_on_reg && !hpt_en) begin
         ramp_on_reg <= 1'b0;
      end else if (ramp_tick) begin
         amp_reg  <= amp_sat;
         seen_reg <= seen_reg || an2_reg[2];
         if (!decel_reg) begin
            vel_reg <= vel_reg + step_w;
            if (amp_sat >= RAMP_HALF) decel_reg <= 1'b1;
         end else if (ramp_last) begin
            ramp_on_reg <= 1'b0;
            load_reg    <= seen_reg || an2_reg[2];
         end else begin
            vel_reg <= vel_reg - step_w;
         end
      end
   end

   assign ramp_amp    = amp_reg;
   assign ramp_active = ramp_on_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and read mux

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RST;
         mask_reg <= 3'h0;
         ev_reg   <= 3'h0;
         step_reg <= STEP_RST;
      end else begin
         ev_reg <= ev_next;
         if (wr && hit_ctl) ctrl_reg <= pwdata;
         if (wr && hit_msk) mask_reg <= pwdata[2:0];
         if (wr && hit_rmp) step_reg <= pwdata[7:0];
      end
   end

   wire [31:0] sts_w = {26'h000_0000, ramp_on_reg, state != S_IDLE,
                        load_reg, order_reg, type_reg, dbus.present};

   assign prdata = hit_ctl ? ctrl_reg
                 : hit_msk ? {29'h0000_0000, mask_reg}
                 : hit_evt ? {29'h0000_0000, ev_reg}
                 : hit_sts ? sts_w
                 : hit_rmp ? {23'h00_0000, ramp_on_reg, step_reg}
                 : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // Cycles since the last insertion pulse; the latency check counts on its own
   logic [23:0] since_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_reg <= 24'h00_0000;
      end else if (dbus.ins_pulse) begin
         since_reg <= 24'h00_0000;
      end else begin
         since_reg <= since_reg + 24'h00_0001;
      end
   end

   // Expected pulse-to-complete span, rebuilt from the latency code and plug type
   wire [23:0] lat_cyc = 24'((int'(LAT_BASE) << (int'(rate) + int'(state == S_ORDER_WAIT)))
                             * MS_CYCLES - 1);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence ramp_start_s;
      ramp_go;
   endsequence

   sequence ramp_hold_s;
      ramp_active ##1 ramp_active;
   endsequence

   sequence abort_s;
      ##1 state == S_IDLE ##1 state == S_IDLE;
   endsequence

   ins_flag_a: assert property (dbus.ins_pulse |=> ev_reg[EV_INS])
      else $error("Insertion did not set its flag");

   rem_flag_a: assert property (dbus.rem_pulse |=> ev_reg[EV_REM])
      else $error("Removal did not set its flag");

   pres_sts_a: assert property (dbus.ins_pulse |=> sts_w[ST_PRES] && sts_w[ST_BUSY])
      else $error("Presence or busy wrong after insertion");

   lat_done_a: assert property (done_set |-> since_reg == lat_cyc)
      else $error("Complete event at wrong latency");

   done_final_a: assert property (done_set |=> state == S_IDLE
         && (!type_reg || $past(state == S_ORDER_WAIT)))
      else $error("Complete before pin order was final");

   mask_keep_a: assert property (dbus.ins_pulse && mask_reg[EV_INS] |=> ev_reg[EV_INS])
      else $error("Masked event lost its flag");

   irq_raise_a: assert property ($rose(ev_reg[EV_DONE]) && !mask_reg[EV_DONE] |-> irq)
      else $error("Unmasked event did not raise interrupt");

   irq_clear_a: assert property (wr && hit_evt && (pwdata[2:0] & ev_reg & ~mask_reg)
         == (ev_reg & ~mask_reg) && ev_set == 3'h0 && !(wr && hit_msk) |=> !irq)
      else $error("Interrupt stayed after clear");

   force_type_a: assert property (state == S_TYPE_WAIT && lat_hit && !tdet_en
         |=> type_reg == $past(tforce))
      else $error("Forced plug type not used");

   order_force_a: assert property (state == S_ORDER_WAIT && lat_hit && !odet_en
         |=> order_reg == $past(oforce))
      else $error("Forced pin order not used");

   ramp_run_a: assert property (ramp_start_s |=> ramp_hold_s)
      else $error("Ramp did not start");

   rem_abort_a: assert property (dbus.rem_pulse |-> abort_s)
      else $error("Removal did not end the sequence");

   pres_clear_a: assert property (dbus.rem_pulse |=> !sts_w[ST_PRES])
      else $error("Presence stayed after removal");

   type_store_a: assert property (state == S_TYPE_WAIT && lat_hit && tdet_en
         |=> type_reg == $past(an2_reg[0]))
      else $error("Measured plug type not stored");

   order_store_a: assert property (state == S_ORDER_WAIT && lat_hit && odet_en
         |=> order_reg == $past(an2_reg[1]))
      else $error("Measured pin order not stored");

   ramp_end_a: assert property ($fell(ramp_active) && hpt_en |-> decel_reg)
      else $error("Ramp ended before slowing down");
endmodule : jack_detect_seq

// ### test/jack_accessory.sv
// Purpose: Plugged accessory model seen by the jack sequencer
// Assumes: Comparator outputs settle while the plug is seated
// Notes:   With no plug the comparator lines float and toggle
`timescale 1ns/1ps
module jack_accessory (
   // Clock
   input  wire logic pclk,
   // Scenario control
   input  wire logic plug_in,
   input  wire logic low_on_insert,
   input  wire logic four,
   input  wire logic mic_third,
   input  wire logic line_load,
   // Socket and comparators
   output logic      plug_sense,
   output logic      type_above,
   output logic      mic_on_second_ring,
   output logic      load_above
);
   logic toggle_reg = 1'b0;
   always @(posedge pclk) toggle_reg <= ~toggle_reg;
   // Socket may pull either way on insertion
   assign plug_sense         = plug_in ^ low_on_insert;
   // Floating lines must not look like a stable result
   assign type_above         = plug_in ? four : toggle_reg;
   assign mic_on_second_ring = plug_in ? mic_third : ~toggle_reg;
   assign load_above         = plug_in ? line_load : toggle_reg;
endmodule : jack_accessory

// ### test/headset_jack_detect_sequencer_test.sv
// Purpose: Self-checking bench for the jack sequencer
// Assumes: One ms is scaled to MSC cycles
// Notes:   Timing checks allow a few cycles for sync and APB
`timescale 1ns/1ps
module headset_jack_detect_sequencer_test;
   import jack_pkg::*;
   localparam int MSC = 20;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, irq, er, ramp_active, type_meas_en, order_meas_en;
   logic        plug_sense, type_above, mic_on_second_ring, load_above;
   logic [1:0]  type_thresh_sel, load_thresh_sel;
   logic [15:0] ramp_amp;
   logic        plug_in = 1'b0, low_ins = 1'b0, four = 1'b0, mic3 = 1'b0, line = 1'b0;
   logic [7:0]  seed = 8'h3A;
   int          miscompares = 0, checked = 0, cyc = 0;

   always #25 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   jack_detect_seq #(.MS_CYCLES(MSC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .plug_sense(plug_sense), .type_above(type_above),
      .mic_on_second_ring(mic_on_second_ring), .load_above(load_above),
      .type_thresh_sel(type_thresh_sel), .load_thresh_sel(load_thresh_sel),
      .type_meas_en(type_meas_en), .order_meas_en(order_meas_en), .ramp_amp(ramp_amp),
      .ramp_active(ramp_active), .irq(irq));
   jack_accessory ACC (.pclk(pclk), .plug_in(plug_in), .low_on_insert(low_ins), .four(four),
      .mic_third(mic3), .line_load(line), .plug_sense(plug_sense), .type_above(type_above),
      .mic_on_second_ring(mic_on_second_ring), .load_above(load_above));

   ////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task automatic summarize();
      if (miscompares == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      chk(32'(pready), 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rdchk

   task automatic wait_to(input int c);
      while (cyc < c) @(posedge pclk);
   endtask : wait_to

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic run_case(input int k);
      int pol, tdet, tf, of, typ, ord, icode, ims, rms, lat, t0, td;
      logic [2:0] mask;
      logic [31:0] ctrl;
      pol = k % 2;
      tdet = (k < 2);
      tf = (k == 2);
      of = (k == 3);
      typ = tdet ? pol : tf;
      ord = tdet ? (typ ? pol : 0) : of;
      icode = pol ? 7 : 0;
      ims = pol ? 1 : 5;
      rms = (k == 0) ? 1 : (k == 1) ? 5 : (k == 2) ? 10 : 20;
      lat = (32 << (k + typ)) * MSC;
      ctrl = tdet | (tf << 1) | (tdet << 2) | (of << 3) | (pol << 5) | (k << 6);
      ctrl = ctrl | (icode << 8) | (k << 12) | (k << 16) | ((3 - k) << 18);
      mask = seed[2:0];
      seed = lfsr(seed);
      low_ins <= pol[0];
      four <= pol[0];
      mic3 <= pol[0];
      apb(1'b1, CTRL_ADDR, ctrl);
      apb(1'b1, MASK_ADDR, 32'(mask));
      chk(32'(type_thresh_sel), 32'(k));
      chk(32'(load_thresh_sel), 32'(3 - k));
      plug_in <= 1'b1;
      repeat (ims * MSC - 6) @(posedge pclk);
      plug_in <= 1'b0;
      repeat (4) @(posedge pclk);
      plug_in <= 1'b1;
      t0 = cyc;
      wait_to(t0 + ims * MSC - 6);
      rdchk(EVT_ADDR, 32'h0);
      wait_to(t0 + ims * MSC + 8);
      rdchk(EVT_ADDR, 32'h1);
      chk(32'(irq), 32'(!mask[0]));
      apb(1'b0, STS_ADDR, 32'h0);
      chk(32'(rd[0]), 32'h1);
      td = t0 + ims * MSC + 3 + lat;
      wait_to(td - 10);
      rdchk(EVT_ADDR, 32'h1);
      wait_to(td + 10);
      rdchk(EVT_ADDR, 32'h5);
      chk(32'(irq), 32'(|(3'h5 & ~mask)));
      apb(1'b0, STS_ADDR, 32'h0);
      chk(32'(rd[2:0]), 32'({ord[0], typ[0], 1'b1}));
      apb(1'b1, EVT_ADDR, 32'h7);
      rdchk(EVT_ADDR, 32'h0);
      chk(32'(irq), 32'h0);
      plug_in <= 1'b0;
      t0 = cyc;
      wait_to(t0 + rms * MSC - 6);
      rdchk(EVT_ADDR, 32'h0);
      wait_to(t0 + rms * MSC + 8);
      rdchk(EVT_ADDR, 32'h2);
      chk(32'(irq), 32'(!mask[1]));
      apb(1'b0, STS_ADDR, 32'h0);
      chk(32'(rd[0]), 32'h0);
      apb(1'b1, EVT_ADDR, 32'h7);
   endtask : run_case

   // Host order: ramp profile, path, start, then read result
   task automatic load_test(input logic l);
      int n;
      logic [15:0] pk;
      n = 0;
      pk = 16'h0000;
      line <= l;
      plug_in <= 1'b1;
      apb(1'b1, RAMP_ADDR, 32'h0000_00FF);
      rdchk(RAMP_ADDR, 32'h0000_00FF);
      apb(1'b1, CTRL_ADDR, 32'h0000_0730);
      apb(1'b1, RAMP_ADDR, 32'h0000_01FF);
      @(posedge pclk);
      chk(32'(ramp_active), 32'h1);
      while (ramp_active === 1'b1 && n < 3000) begin
         @(posedge pclk);
         if (ramp_amp > pk) pk = ramp_amp;
         n++;
      end
      chk(32'(n < 3000), 32'h1);
      chk(32'(pk[15]), 32'h1);
      apb(1'b0, STS_ADDR, 32'h0);
      chk(32'({rd[5], rd[3]}), 32'({1'b0, l}));
      plug_in <= 1'b0;
      repeat (60) @(posedge pclk);
      apb(1'b1, EVT_ADDR, 32'h7);
   endtask : load_test

   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(CTRL_ADDR, CTRL_RST);
      rdchk(MASK_ADDR, 32'h0);
      chk(32'(type_thresh_sel), 32'h1);
      apb(1'b0, 8'h14, 32'h0);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
      rdchk(STS_ADDR, 32'h0);
      for (int k = 0; k < 4; k++) run_case(k);
      load_test(1'b1);
      load_test(1'b0);
      summarize();
   end

   initial begin
      repeat (40000) @(posedge pclk);
      miscompares++;
      summarize();
   end
endmodule : headset_jack_detect_sequencer_test
